/* cwt_pkg.sv */
// ============================================================
// shared constants and types of the carrier wave timer
package cwt_pkg;

    // register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets, one per instruction-level operation
    localparam logic [3:0] ADR_CTRL      = 4'h0; // control, read/write
    localparam logic [3:0] ADR_COUNT_LOW = 4'h1; // write count and low reload, read count
    localparam logic [3:0] ADR_COPY_LOW  = 4'h2; // write: count takes low reload
    localparam logic [3:0] ADR_HIGH      = 4'h3; // high reload, read/write
    localparam logic [3:0] ADR_INT_STAT  = 4'h4; // sticky event status, read only
    localparam logic [3:0] ADR_INT_CLR   = 4'h5; // write one to clear status, write only
    localparam logic [3:0] ADR_INT_EN    = 4'h6; // interrupt enable
    localparam logic [3:0] ADR_SKIP_2ND  = 4'h7; // read: second flag, cleared when set
    localparam logic [3:0] ADR_SKIP_1ST  = 4'h8; // read: first flag, cleared when set

    // control bit positions
    localparam int CTL_RUN    = 0;
    localparam int CTL_SRC    = 1;
    localparam int CTL_CARRIER_OUTPUT_PIN   = 2;
    localparam int CTL_EXPAND = 3;

    // event bit positions in status and enable
    localparam int EV_2ND = 0;
    localparam int EV_1ST = 1;

    // reset values
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    localparam logic [1:0] EV_RST    = 2'h0;

    // system clock of the timer is clk/2, its half is clk/4
    localparam int         CLK_MHZ      = 50;
    localparam logic [1:0] SRC_LAST_SYS = 2'h1; // prescaler terminal, 2 clk period
    localparam logic [1:0] SRC_LAST_HLF = 2'h3; // prescaler terminal, 4 clk period
    localparam logic [1:0] STR_SYS      = 2'h1; // half source period, in clk
    localparam logic [1:0] STR_HLF      = 2'h2;
    localparam logic [1:0] STR_NONE     = 2'h0;
    localparam logic [1:0] STR_LAST     = 2'h1;
    localparam logic [7:0] CNT_ZERO     = 8'h00;
    localparam logic [7:0] CNT_ONE      = 8'h01;

    // control register layout
    typedef struct packed {
        logic expand;
        logic carrier_output_pin_en;
        logic src_half;
        logic run;
    } cwt_ctrl_t;

    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cwt_req_t;

endpackage : cwt_pkg

/* cwt_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// count source prescaler: one tick per source period
module cwt_prescale (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // control
    input  wire logic       clear_i,
    input  wire logic       half_i,
    // count pulse
    output logic            tick_o
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [1:0] last;

    // restarting on clear keeps the first period after start a full one
    always_comb begin
        last    = half_i ? cwt_pkg::SRC_LAST_HLF : cwt_pkg::SRC_LAST_SYS;
        cnt_nxt = (clear_i || cnt_r == last) ? 2'h0 : 2'(cnt_r + 2'h1);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick_o = !clear_i && cnt_r == last;

endmodule : cwt_prescale
`default_nettype wire

/* cwt_top.sv */
// Function
// - count pulse at zero sets second flag, reloads low value, keeps counting
// - low reload n divides the count source by n plus one
// - carrier enable gives carrier: low from low reload, high from high reload
// - carrier mode: underflow ending low phase reloads high value, sets flag
// - carrier mode: later underflows set flag, reload low and high alternately
// - no expansion: high interval is n plus one source periods
// - expansion: high interval is n plus one and a half periods
// - low interval is m plus one source periods
// - count readable by read instruction; software stops counter first
// - each timer underflow sets its flag; skip instruction tests it
// - skip finding a flag set clears that flag
// - reset clears both underflow flags
// - control: run, source half, carrier enable, high expansion
// - load count with low, copy low to count, load high reload
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cwt_top (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // first timer underflow event, same clock
    input  wire logic       first_underflow_i,
    // outputs
    output logic            carrier_output_pin_o,
    output logic            irq_o
);
    // ============================================================
    // state
    typedef struct packed {
        cwt_pkg::cwt_ctrl_t ctrl;
        logic [7:0]         count;
        logic [7:0]         low;
        logic [7:0]         high;
        logic               phase_high;
        logic [1:0]         stretch;
        logic               flag_1st;
        logic               flag_2nd;
        logic [1:0]         int_stat;
        logic [1:0]         int_en;
        logic [7:0]         rdata;
        logic               carrier;
        logic               irq;
    } cwt_state_t;

    cwt_state_t       st_r;
    cwt_state_t       st_nxt;
    cwt_pkg::cwt_req_t req;
    logic             tick;
    logic             underflow;
    logic             skip2_hit;
    logic             skip1_hit;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // ============================================================
    // count source
    // prescaler held while stopped or during the high stretch
    cwt_prescale u_pre (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clear_i (!st_r.ctrl.run || st_r.stretch != cwt_pkg::STR_NONE),
        .half_i  (st_r.ctrl.src_half),
        .tick_o  (tick)
    );

    // underflow: the pulse that arrives while the count is zero
    assign underflow = tick && st_r.count == cwt_pkg::CNT_ZERO;
    assign skip2_hit = req.rd && req.addr == cwt_pkg::ADR_SKIP_2ND && st_r.flag_2nd;
    assign skip1_hit = req.rd && req.addr == cwt_pkg::ADR_SKIP_1ST && st_r.flag_1st;

    // ============================================================
    // next state
    always_comb begin
        st_nxt = st_r;

        // counting; stretch runs down a half source period
        if (st_r.stretch != cwt_pkg::STR_NONE) begin
            st_nxt.stretch = 2'(st_r.stretch - 2'h1);
        end
        if (underflow) begin
            if (st_r.ctrl.carrier_output_pin_en && !st_r.phase_high) begin
                st_nxt.count      = st_r.high;
                st_nxt.phase_high = 1'b1;
            end else begin
                st_nxt.count      = st_r.low;
                st_nxt.phase_high = 1'b0;
                if (st_r.ctrl.carrier_output_pin_en && st_r.ctrl.expand) begin
                    // high stays up half a period longer than the count
                    st_nxt.stretch = st_r.ctrl.src_half ? cwt_pkg::STR_HLF
                                                        : cwt_pkg::STR_SYS;
                end
            end
        end else if (tick) begin
            st_nxt.count = 8'(st_r.count - cwt_pkg::CNT_ONE);
        end

        // skip instructions clear a set flag, a new event wins
        if (skip2_hit) begin
            st_nxt.flag_2nd = 1'b0;
        end
        if (skip1_hit) begin
            st_nxt.flag_1st = 1'b0;
        end
        if (underflow) begin
            st_nxt.flag_2nd = 1'b1;
        end
        if (first_underflow_i) begin
            st_nxt.flag_1st = 1'b1;
        end

        // register writes
        if (req.wr) begin
            case (req.addr)
                cwt_pkg::ADR_CTRL: begin
                    st_nxt.ctrl = cwt_pkg::cwt_ctrl_t'(req.wdata[3:0]);
                    if (!req.wdata[cwt_pkg::CTL_CARRIER_OUTPUT_PIN]) begin
                        st_nxt.phase_high = 1'b0;
                        st_nxt.stretch    = cwt_pkg::STR_NONE;
                    end
                end
                cwt_pkg::ADR_COUNT_LOW: begin
                    st_nxt.count = req.wdata;
                    st_nxt.low   = req.wdata;
                end
                cwt_pkg::ADR_COPY_LOW: st_nxt.count = st_r.low;
                cwt_pkg::ADR_HIGH:     st_nxt.high  = req.wdata;
                cwt_pkg::ADR_INT_EN:   st_nxt.int_en = req.wdata[1:0];
                default: ;
            endcase
        end

        // sticky events: clear by writing ones, a set in the same cycle wins
        if (req.wr && req.addr == cwt_pkg::ADR_INT_CLR) begin
            st_nxt.int_stat = st_r.int_stat & ~req.wdata[1:0];
        end
        st_nxt.int_stat[cwt_pkg::EV_2ND] = st_nxt.int_stat[cwt_pkg::EV_2ND] | underflow;
        st_nxt.int_stat[cwt_pkg::EV_1ST] = st_nxt.int_stat[cwt_pkg::EV_1ST]
                                           | first_underflow_i;

        // read data, valid only the cycle after the strobe
        st_nxt.rdata = cwt_pkg::BYTE_RST;
        if (req.rd) begin
            case (req.addr)
                cwt_pkg::ADR_CTRL:      st_nxt.rdata = {4'h0, st_r.ctrl};
                cwt_pkg::ADR_COUNT_LOW: st_nxt.rdata = st_r.count;
                cwt_pkg::ADR_HIGH:      st_nxt.rdata = st_r.high;
                cwt_pkg::ADR_INT_STAT:  st_nxt.rdata = {6'h00, st_r.int_stat};
                cwt_pkg::ADR_INT_EN:    st_nxt.rdata = {6'h00, st_r.int_en};
                cwt_pkg::ADR_SKIP_2ND:  st_nxt.rdata = {7'h00, st_r.flag_2nd};
                cwt_pkg::ADR_SKIP_1ST:  st_nxt.rdata = {7'h00, st_r.flag_1st};
                default:                st_nxt.rdata = cwt_pkg::BYTE_RST;
            endcase
        end

        // carrier: high during the high count and its stretch
        st_nxt.carrier = st_nxt.ctrl.carrier_output_pin_en
                         && (st_nxt.phase_high || st_nxt.stretch != cwt_pkg::STR_NONE);
        st_nxt.irq     = |(st_nxt.int_stat & st_nxt.int_en);
    end

    // ============================================================
    // registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r            <= '0;
            st_r.ctrl       <= cwt_pkg::cwt_ctrl_t'(cwt_pkg::CTRL_RST);
            st_r.flag_1st   <= 1'b0;
            st_r.flag_2nd   <= 1'b0;
            st_r.int_stat   <= cwt_pkg::EV_RST;
            st_r.int_en     <= cwt_pkg::EV_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o              = st_r.rdata;
    assign carrier_output_pin_o = st_r.carrier;
    assign irq_o                = st_r.irq;

    // ============================================================
    // checks
    AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        underflow |=> st_r.flag_2nd) else $error("underflow did not set flag");

    AST_RELOAD_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        underflow && !st_r.ctrl.carrier_output_pin_en && !wr_i |=> st_r.count == $past(st_r.low))
        else $error("no reload from low value");

    AST_RELOAD_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        underflow && st_r.ctrl.carrier_output_pin_en && !st_r.phase_high && !wr_i
        |=> st_r.count == $past(st_r.high) && st_r.phase_high && carrier_output_pin_o)
        else $error("no reload from high value");

    AST_ALTERNATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        underflow && st_r.ctrl.carrier_output_pin_en && st_r.phase_high && !wr_i
        |=> !st_r.phase_high && st_r.count == $past(st_r.low))
        else $error("phases do not alternate");

    AST_DECREMENT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tick && st_r.count != cwt_pkg::CNT_ZERO && !wr_i
        |=> st_r.count == $past(st_r.count) - cwt_pkg::CNT_ONE)
        else $error("count did not step down");

    AST_STRETCH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        underflow && st_r.phase_high && st_r.ctrl.carrier_output_pin_en && st_r.ctrl.expand
        && !st_r.ctrl.src_half && !wr_i |=> carrier_output_pin_o ##1 !carrier_output_pin_o)
        else $error("high stretch wrong length");

    AST_NO_CARRIER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !st_r.ctrl.carrier_output_pin_en && !wr_i |=> !carrier_output_pin_o)
        else $error("carrier without enable");

    AST_SKIP_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        skip2_hit && !underflow |=> !st_r.flag_2nd && rdata_o == 8'h01)
        else $error("skip did not clear flag");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        skip2_hit && underflow |=> st_r.flag_2nd)
        else $error("event lost on clear");

    // the first timer flag follows the same priority as the second
    AST_SET_WINS_1ST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        skip1_hit && first_underflow_i |=> st_r.flag_1st)
        else $error("first timer event lost on clear");

    AST_READ_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rd_i && addr_i == cwt_pkg::ADR_COUNT_LOW |=> rdata_o == $past(st_r.count))
        else $error("count read wrong");

    AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !st_r.ctrl.run && !wr_i |=> $stable(st_r.count))
        else $error("count moved while stopped");

    AST_RESET_FLAGS: assert property (@(posedge clk_i)
        $rose(rst_b_i) |-> !st_r.flag_1st && !st_r.flag_2nd)
        else $error("flags not cleared by reset");

endmodule : cwt_top
`default_nettype wire

/* carrier_wave_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench of the carrier wave timer
module carrier_wave_timer_bench;
    // design ports, every input given a value at time zero
    logic       clk_i             = 1'b0;
    logic       rst_b_i           = 1'b0;
    logic [3:0] addr_i            = 4'h0;
    logic [7:0] wdata_i           = 8'h00;
    logic       wr_i              = 1'b0;
    logic       rd_i              = 1'b0;
    logic       first_underflow_i = 1'b0;
    logic [7:0] rdata_o;
    logic       carrier_output_pin_o;
    logic       irq_o;
    // scoreboard and bookkeeping
    logic [7:0] exp_q[$];
    logic       rd_seen    = 1'b0;
    int         num_errors = 0;
    int         cmp_count  = 0;
    int         cyc_cnt    = 0;
    int         t0, t1, p, m, n;

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    cwt_top u_cwt_top (
        .clk_i                (clk_i),
        .rst_b_i              (rst_b_i),
        .addr_i               (addr_i),
        .wdata_i              (wdata_i),
        .wr_i                 (wr_i),
        .rd_i                 (rd_i),
        .rdata_o              (rdata_o),
        .first_underflow_i    (first_underflow_i),
        .carrier_output_pin_o (carrier_output_pin_o),
        .irq_o                (irq_o)
    );

    // ============================================================
    // checking and closing
    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (rd_seen) begin
            check({8'h00, rdata_o}, exp_q.pop_front());
        end
        rd_seen <= rd_i;
    end

    // ============================================================
    // bus tasks: strobes are held, not dropped, so back-to-back calls never
    // assign a strobe twice in one time step; idle drops them
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        @(posedge clk_i);
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr_i <= a;
        rd_i   <= 1'b1;
        wr_i   <= 1'b0;
        @(posedge clk_i);
    endtask : bus_rd

    task automatic idle(input int k);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (k) @(posedge clk_i);
    endtask : idle

    // bounded wait for the carrier pin (which=1) or irq (which=0) to reach v
    task automatic wait_for(input logic which, input logic v);
        int k;
        k = 0;
        while (((which ? carrier_output_pin_o : irq_o) !== v) && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 3000) begin
            num_errors++;
            $display("BAD t=%0t wait ran out", $time);
        end
    endtask : wait_for

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(34));
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        check({15'h0000, irq_o}, 16'h0000);
        check({15'h0000, carrier_output_pin_o}, 16'h0000);
        bus_rd(cwt_pkg::ADR_CTRL, 8'h00);
        bus_rd(cwt_pkg::ADR_SKIP_2ND, 8'h00);
        bus_rd(cwt_pkg::ADR_SKIP_1ST, 8'h00);
        bus_rd(4'h9, 8'h00);
        bus_wr(cwt_pkg::ADR_CTRL, 8'hFE);
        bus_rd(cwt_pkg::ADR_CTRL, 8'h0E);
        n = 3 + $urandom % 8;
        bus_wr(cwt_pkg::ADR_CTRL, 8'h00);
        bus_wr(cwt_pkg::ADR_COUNT_LOW, n[7:0]);
        bus_rd(cwt_pkg::ADR_COUNT_LOW, n[7:0]);
        bus_wr(cwt_pkg::ADR_HIGH, 8'hA5);
        bus_rd(cwt_pkg::ADR_HIGH, 8'hA5);
        bus_wr(cwt_pkg::ADR_INT_STAT, 8'hFF);
        bus_rd(cwt_pkg::ADR_INT_STAT, 8'h00);
        // event from the first timer, then its skip clears the flag
        // a second event in the cycle of the clearing skip keeps the flag
        first_underflow_i <= 1'b1;
        idle(1);
        bus_rd(cwt_pkg::ADR_SKIP_1ST, 8'h01);
        first_underflow_i <= 1'b0;
        bus_rd(cwt_pkg::ADR_INT_STAT, 8'h02);
        bus_rd(cwt_pkg::ADR_SKIP_1ST, 8'h01);
        bus_rd(cwt_pkg::ADR_SKIP_1ST, 8'h00);
        bus_wr(cwt_pkg::ADR_INT_CLR, 8'h02);
        bus_rd(cwt_pkg::ADR_INT_STAT, 8'h00);
        // plain timer mode: underflow period seen through the interrupt
        bus_wr(cwt_pkg::ADR_INT_EN, 8'h01);
        bus_rd(cwt_pkg::ADR_INT_EN, 8'h01);
        bus_wr(cwt_pkg::ADR_CTRL, 8'h01);
        idle(1);
        wait_for(1'b0, 1'b1);
        bus_rd(cwt_pkg::ADR_SKIP_2ND, 8'h01);
        bus_rd(cwt_pkg::ADR_SKIP_2ND, 8'h00);
        bus_wr(cwt_pkg::ADR_INT_CLR, 8'h01);
        idle(2);
        check({15'h0000, irq_o}, 16'h0000);
        wait_for(1'b0, 1'b1);
        t0 = cyc_cnt;
        bus_wr(cwt_pkg::ADR_INT_CLR, 8'h01);
        idle(2);
        wait_for(1'b0, 1'b1);
        check(16'(cyc_cnt - t0), 16'((n + 1) * 2));
        // masking drops the line while the status bit stays
        bus_wr(cwt_pkg::ADR_INT_EN, 8'h00);
        idle(2);
        check({15'h0000, irq_o}, 16'h0000);
        bus_rd(cwt_pkg::ADR_INT_STAT, 8'h01);
        // stopped counter keeps its value; copy restores the low reload
        bus_wr(cwt_pkg::ADR_CTRL, 8'h00);
        bus_wr(cwt_pkg::ADR_COPY_LOW, 8'h00);
        bus_rd(cwt_pkg::ADR_COUNT_LOW, n[7:0]);
        idle(5);
        bus_rd(cwt_pkg::ADR_COUNT_LOW, n[7:0]);
        // carrier mode over both sources, expansion off and on
        for (int i = 0; i < 4; i++) begin
            p = i[0] ? 4 : 2;
            m = $urandom % 6;
            n = 1 + $urandom % 6;
            bus_wr(cwt_pkg::ADR_CTRL, 8'h00);
            bus_wr(cwt_pkg::ADR_COUNT_LOW, m[7:0]);
            bus_wr(cwt_pkg::ADR_HIGH, n[7:0]);
            bus_wr(cwt_pkg::ADR_CTRL, {4'h0, i[1], 1'b1, i[0], 1'b1});
            idle(1);
            // the first low phase carries the start delay, so skip it
            wait_for(1'b1, 1'b0);
            wait_for(1'b1, 1'b1);
            t0 = cyc_cnt;
            wait_for(1'b1, 1'b0);
            t1 = cyc_cnt;
            wait_for(1'b1, 1'b1);
            check(16'(t1 - t0), 16'((n + 1) * p + (i[1] ? p / 2 : 0)));
            check(16'(cyc_cnt - t1), 16'((m + 1) * p));
        end
        bus_wr(cwt_pkg::ADR_CTRL, 8'h00);
        idle(3);
        stop_test();
    end

    // watchdog: the whole run needs a few hundred cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        $display("BAD t=%0t run did not finish", $time);
        stop_test();
    end

endmodule : carrier_wave_timer_bench
`default_nettype wire
